// ### rtl/imu_out_pkg.sv
// Constants for the inertial output word block.
// Assumes a 250 MHz core clock and 16-bit registers at byte addresses.
package imu_out_pkg;
    // Register byte addresses
    localparam logic [6:0] ZACC_LO_ADDR = 7'h18;
    localparam logic [6:0] ZACC_HI_ADDR = 7'h1a;
    localparam logic [6:0] TEMP_ADDR = 7'h1c;
    localparam logic [6:0] TIME_ADDR = 7'h1e;
    localparam logic [6:0] CNT_ADDR = 7'h22;
    localparam logic [6:0] X_LO_ADDR = 7'h24;
    localparam logic [6:0] X_HI_ADDR = 7'h26;
    localparam logic [6:0] Y_LO_ADDR = 7'h28;
    localparam logic [6:0] Y_HI_ADDR = 7'h2a;
    // Timing mode field of misc_control
    localparam int MODE_LSB = 2;
    localparam int MODE_MSB = 4;
    localparam logic [2:0] MODE_SCALED = 3'h2;
    // Reset values
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;
    // Delta angle full-scale choices, degrees
    localparam int DANG_RANGE_A = 360;
    localparam int DANG_RANGE_B = 720;
    localparam int DANG_RANGE_C = 2160;
    // Timing
    localparam real CLK_PERIOD_NS = 4.0;
    localparam int SAMPLE_RATE_SPS = 2000;
    localparam real TIME_LSB_US = 49.02;
    localparam int SAMPLE_DIV_CYC =
        int'(1.0e9 / (CLK_PERIOD_NS * SAMPLE_RATE_SPS));
    localparam int TIME_LSB_CYC =
        int'(TIME_LSB_US * 1000.0 / CLK_PERIOD_NS);
endpackage

// ### rtl/imu_out_words.sv
// Output word logic: delta angle integration, counters, register reads.
// Assumes sensor words arrive on core_clk; host reads on link_clk.
//
// Overview of operation
// (RULE1) Z accel high word: 16-bit two's complement, 0.25 mg per count.
// (RULE2) Z accel low word extends the high word to 32 bits.
// (RULE3) Temperature word: two's complement, 0.1 C per count, zero is 0.
// (RULE4) Elapsed-time word since last sync pulse, 49.02 us per count.
// (RULE5) Elapsed-time word is kept only in scaled timing mode 010.
// (RULE6) Each update loads elapsed time of its final sample.
// (RULE7) Update counter clears on reset, increments per data update.
// (RULE8) Update counter wraps from 0xffff to zero and continues.
// (RULE9) Delta angle sums adjacent gyro pairs over D samples, over 2fs.
// (RULE10) D equals decimation setting plus one.
// (RULE11) Internal sample clock runs at 2000 samples per second.
// (RULE12) Host may rescale delta angles by measured data-ready rate.
// (RULE13) Delta angle is 32 bits, high word over low word.
// (RULE14) Full-scale range is fixed per variant: 360, 720 or 2160.
// (RULE15) Delta angle high word LSB equals range over 2^15.
// (RULE16) Low word holds lower 16 bits of the delta angle.
// (RULE17) All words of one update change together.
`timescale 1ns/10ps
module imu_out_words
    import imu_out_pkg::*;
#(
    parameter int SAMPLE_DIV = SAMPLE_DIV_CYC,
    parameter int TIME_DIV = TIME_LSB_CYC,
    parameter int GYRO_W = 32,
    parameter int ACC_W = 48,
    parameter int DANG_SHIFT = 1,
    parameter int DEC_W = 11,
    parameter int DANG_RANGE_DEG = DANG_RANGE_A
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic signed [GYRO_W-1:0] gyro_x,
    input wire logic signed [GYRO_W-1:0] gyro_y,
    input wire logic [31:0] accel_z,
    input wire logic [15:0] temp_in,
    input wire logic [15:0] misc_control,
    input wire logic [DEC_W-1:0] decimation_setting,
    input wire logic reset_cmd,
    input wire logic sync_pin,
    input wire logic link_clk,
    input wire logic rd_en,
    input wire logic [6:0] rd_addr,
    output logic [15:0] rd_data,
    output logic new_sample_flag_pin
);
    localparam int DIV_W = $clog2(SAMPLE_DIV + 1);
    localparam int TDIV_W = $clog2(TIME_DIV + 1);

    // Sync pin synchroniser and edge detect
    logic sync_ff1_reg, sync_ff2_reg, sync_ff3_reg;
    wire sync_edge = sync_ff2_reg & ~sync_ff3_reg;
    always_ff @(posedge core_clk) begin
        sync_ff1_reg <= rst ? 1'b0 : sync_pin;
        sync_ff2_reg <= rst ? 1'b0 : sync_ff1_reg;
        sync_ff3_reg <= rst ? 1'b0 : sync_ff2_reg;
    end

    // Internal sample clock divider
    logic [DIV_W-1:0] div_reg;
    wire samp_tick = div_reg == DIV_W'(SAMPLE_DIV - 1); // see RULE11
    always_ff @(posedge core_clk) begin
        if (rst || samp_tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // Elapsed time since the last sync edge
    logic [TDIV_W-1:0] tdiv_reg;
    logic [15:0] elapsed_reg;
    wire tdiv_wrap = tdiv_reg == TDIV_W'(TIME_DIV - 1);
    wire scaled_mode = misc_control[MODE_MSB:MODE_LSB] == MODE_SCALED;
    wire [15:0] time_pick = scaled_mode ? elapsed_reg : WORD_RESET; // see RULE5
    always_ff @(posedge core_clk) begin
        if (rst || sync_edge) begin
            tdiv_reg <= '0;
            elapsed_reg <= WORD_RESET;
        end else if (tdiv_wrap) begin // see RULE4
            tdiv_reg <= '0;
            if (elapsed_reg != 16'hffff) begin
                elapsed_reg <= elapsed_reg + 16'h0001;
            end
        end else begin
            tdiv_reg <= tdiv_reg + 1'b1;
        end
    end

    // Decimation period sample count
    logic [DEC_W-1:0] samp_cnt_reg;
    wire period_first = samp_cnt_reg == '0;
    wire period_last = samp_cnt_reg >= decimation_setting; // see RULE10
    wire update = samp_tick & period_last;
    always_ff @(posedge core_clk) begin
        if (rst || update) begin
            samp_cnt_reg <= '0;
        end else if (samp_tick) begin
            samp_cnt_reg <= samp_cnt_reg + 1'b1;
        end
    end

    // Per-axis trapezoidal integrator
    logic signed [GYRO_W-1:0] gyro_a [2];
    logic [31:0] dang_w [2];
    assign gyro_a[0] = gyro_x;
    assign gyro_a[1] = gyro_y;
    for (genvar i = 0; i < 2; i++) begin : ax
        logic signed [GYRO_W-1:0] prev_reg;
        logic signed [ACC_W-1:0] acc_reg;
        logic signed [ACC_W-1:0] pair;
        logic signed [ACC_W-1:0] base;
        logic signed [ACC_W-1:0] sum;
        logic signed [ACC_W-1:0] scaled;
        logic [31:0] dang_reg;
        assign pair = {{(ACC_W-GYRO_W){gyro_a[i][GYRO_W-1]}}, gyro_a[i]}
            + {{(ACC_W-GYRO_W){prev_reg[GYRO_W-1]}}, prev_reg};
        assign base = period_first ? '0 : acc_reg;
        assign sum = base + pair; // see RULE9
        assign scaled = sum >>> DANG_SHIFT; // see RULE9
        always_ff @(posedge core_clk) begin
            if (rst) begin
                prev_reg <= '0;
                acc_reg <= '0;
                dang_reg <= '0;
            end else if (samp_tick) begin
                prev_reg <= gyro_a[i];
                acc_reg <= sum;
                if (update) begin
                    dang_reg <= scaled[31:0]; // see RULE13
                end
            end
        end
        assign dang_w[i] = dang_reg;
    end

    // Output bank, loaded as one on each update
    logic [15:0] cnt_reg;
    logic [15:0] time_reg;
    logic [15:0] temp_reg;
    logic [31:0] accz_reg;
    logic upd_tgl_reg;
    logic flag_reg;
    always_ff @(posedge core_clk) begin
        if (rst || reset_cmd) begin
            cnt_reg <= CNT_RESET; // see RULE7
        end else if (update) begin
            cnt_reg <= cnt_reg + 16'h0001; // see RULE8
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            time_reg <= WORD_RESET;
            temp_reg <= WORD_RESET;
            accz_reg <= '0;
            upd_tgl_reg <= 1'b0;
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= update; // see RULE17
            if (update) begin
                time_reg <= time_pick; // see RULE6
                temp_reg <= temp_in; // see RULE3
                accz_reg <= accel_z; // see RULE1
                upd_tgl_reg <= ~upd_tgl_reg; // see RULE17
            end
        end
    end
    assign new_sample_flag_pin = flag_reg;

    // Link domain: reset and update event crossing
    logic lrst_ff1_reg, lrst_ff2_reg;
    logic tgl_ff1_reg, tgl_ff2_reg, tgl_ff3_reg;
    wire lrst = lrst_ff2_reg;
    wire load_evt = tgl_ff2_reg ^ tgl_ff3_reg;
    always_ff @(posedge link_clk) begin
        lrst_ff1_reg <= rst;
        lrst_ff2_reg <= lrst_ff1_reg;
        tgl_ff1_reg <= upd_tgl_reg;
        tgl_ff2_reg <= tgl_ff1_reg;
        tgl_ff3_reg <= tgl_ff2_reg;
    end

    // Link copy of the bank; bank holds a full sample period
    logic [15:0] l_cnt_reg, l_time_reg, l_temp_reg;
    logic [31:0] l_accz_reg, l_x_reg, l_y_reg;
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            l_cnt_reg <= CNT_RESET;
            l_time_reg <= WORD_RESET;
            l_temp_reg <= WORD_RESET;
            l_accz_reg <= '0;
            l_x_reg <= '0;
            l_y_reg <= '0;
        end else if (load_evt) begin // see RULE17
            l_cnt_reg <= cnt_reg;
            l_time_reg <= time_reg;
            l_temp_reg <= temp_reg;
            l_accz_reg <= accz_reg;
            l_x_reg <= dang_w[0];
            l_y_reg <= dang_w[1];
        end
    end

    // Read decode
    logic [15:0] rd_mux;
    always_comb begin
        unique case (rd_addr)
            ZACC_LO_ADDR: rd_mux = l_accz_reg[15:0]; // see RULE2
            ZACC_HI_ADDR: rd_mux = l_accz_reg[31:16]; // see RULE1
            TEMP_ADDR: rd_mux = l_temp_reg;
            TIME_ADDR: rd_mux = l_time_reg; // see RULE5
            CNT_ADDR: rd_mux = l_cnt_reg;
            X_LO_ADDR: rd_mux = l_x_reg[15:0]; // see RULE16
            X_HI_ADDR: rd_mux = l_x_reg[31:16]; // see RULE15
            Y_LO_ADDR: rd_mux = l_y_reg[15:0]; // see RULE16
            Y_HI_ADDR: rd_mux = l_y_reg[31:16]; // see RULE15
            default: rd_mux = UNMAPPED_READ;
        endcase
    end
    logic [15:0] rd_data_reg;
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            rd_data_reg <= UNMAPPED_READ;
        end else if (rd_en) begin
            rd_data_reg <= rd_mux;
        end
    end
    assign rd_data = rd_data_reg;

    // Checks, core domain
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_cnt_step: assert property (update && !reset_cmd |=> // see RULE7
        cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("update counter did not step");
    a_cnt_wrap: assert property ( // see RULE8
        update && !reset_cmd && cnt_reg == 16'hffff |=> cnt_reg == CNT_RESET)
        else $error("update counter did not wrap");
    a_cnt_clear: assert property ( // see RULE7
        reset_cmd |=> cnt_reg == CNT_RESET)
        else $error("update counter not cleared");
    a_time_mode: assert property ( // see RULE5
        update && !scaled_mode |=> time_reg == WORD_RESET)
        else $error("elapsed time kept outside scaled mode");
    a_time_load: assert property ( // see RULE6
        update && scaled_mode |=> time_reg == $past(elapsed_reg))
        else $error("elapsed time not final sample");
    a_sync_clear: assert property ( // see RULE4
        sync_edge |=> elapsed_reg == WORD_RESET && tdiv_reg == '0)
        else $error("elapsed time not restarted at sync");
    a_tick_space: assert property (samp_tick |=> !samp_tick [*2]) // see RULE11
        else $error("sample ticks too close");
    a_period_len: assert property ( // see RULE10
        samp_tick && !period_last |=> !new_sample_flag_pin
        && samp_cnt_reg == $past(samp_cnt_reg) + 1'b1)
        else $error("period ended early");
    a_dang_load: assert property (update |=> // see RULE13
        ax[0].dang_reg == $past(ax[0].scaled[31:0]) &&
        ax[1].dang_reg == $past(ax[1].scaled[31:0]))
        else $error("delta angle not loaded");
    a_first_pair: assert property ( // see RULE9
        samp_tick && period_first |=> ax[0].acc_reg == $past(ax[0].pair))
        else $error("period sum not restarted");
    a_bank_flag: assert property ( // see RULE17
        update |=> new_sample_flag_pin && upd_tgl_reg != $past(upd_tgl_reg)
        && temp_reg == $past(temp_in) && accz_reg == $past(accel_z))
        else $error("bank not loaded together");
    a_range_fixed: assert property ( // see RULE14
        DANG_RANGE_DEG inside {DANG_RANGE_A, DANG_RANGE_B, DANG_RANGE_C})
        else $error("delta angle range not a variant");
    a_elapsed_step: assert property ( // see RULE4
        tdiv_wrap && !sync_edge && elapsed_reg != 16'hffff |=>
        elapsed_reg == $past(elapsed_reg) + 16'h0001)
        else $error("elapsed time did not step");
    a_elapsed_hold: assert property ( // see RULE4
        !tdiv_wrap && !sync_edge |=> $stable(elapsed_reg))
        else $error("elapsed time moved between steps");
    a_cnt_hold: assert property ( // see RULE7
        !update && !reset_cmd |=> $stable(cnt_reg))
        else $error("update counter moved without update");
    a_time_hold: assert property (!update |=> $stable(time_reg)) // see RULE17
        else $error("elapsed word moved without update");
    a_dang_hold: assert property ( // see RULE17
        !update |=> $stable(ax[0].dang_reg) && $stable(ax[1].dang_reg))
        else $error("delta angle moved without update");
    a_pair_carry: assert property ( // see RULE9
        samp_tick |=> ax[0].prev_reg == $past(gyro_x)
        && ax[1].prev_reg == $past(gyro_y))
        else $error("previous sample not carried");
    a_flag_pulse: assert property ( // see RULE17
        new_sample_flag_pin |=> !new_sample_flag_pin)
        else $error("update flag longer than one cycle");

    // Checks, link domain
    a_link_copy: assert property ( // see RULE17
        @(posedge link_clk) disable iff (lrst)
        load_evt |=> l_cnt_reg == $past(cnt_reg)
        && l_x_reg == $past(dang_w[0]))
        else $error("link bank not copied together");
    a_x_low: assert property ( // see RULE16
        @(posedge link_clk) disable iff (lrst)
        rd_en && rd_addr == X_LO_ADDR |=> rd_data == $past(l_x_reg[15:0]))
        else $error("x low word not read");
    a_x_high: assert property ( // see RULE15
        @(posedge link_clk) disable iff (lrst)
        rd_en && rd_addr == X_HI_ADDR |=> rd_data == $past(l_x_reg[31:16]))
        else $error("x high word not read");
endmodule

// ### testbench/host_model.sv
// Host model issuing register reads on the link-clock read port.
// Assumes rd_data is loaded at the rising link_clk edge that takes rd_en.
`timescale 1ns/10ps
module host_model (
    input wire logic link_clk,
    output logic rd_en,
    output logic [6:0] rd_addr,
    input wire logic [15:0] rd_data
);
    initial begin
        rd_en = 1'b0;
        rd_addr = 7'h00;
    end
    // Request held over the taking edge, address scrambled once released
    task automatic rd(input logic [6:0] addr, output logic [15:0] data);
        @(negedge link_clk);
        rd_en = 1'b1;
        rd_addr = addr;
        @(posedge link_clk);
        @(negedge link_clk);
        data = rd_data;
        rd_en = 1'b0;
        rd_addr = ~addr;
    endtask
endmodule

// ### testbench/test_imu_out_words.sv
// Testbench for the output word block, read through the host model.
// Assumes short sample and time dividers; the link clock runs at 80 ns.
`timescale 1ns/10ps
module test_imu_out_words;
    import imu_out_pkg::*;
    localparam int TDIV = 5;
    localparam int SDIV = 200;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic signed [31:0] gyro_x = 32'sh00012345;
    logic signed [31:0] gyro_y = -32'sd3;
    logic [31:0] accel_z = 32'h83001234;
    logic [15:0] temp_in = 16'hfe70;
    logic [15:0] misc_control = 16'h0000;
    logic [10:0] decimation_setting = 11'h001;
    logic reset_cmd = 1'b0;
    logic sync_pin = 1'b0;
    logic rd_en;
    logic [6:0] rd_addr;
    logic [15:0] rd_data;
    logic new_sample_flag_pin;
    int bad_count = 0;
    int n_checks = 0;
    always #2 core_clk = ~core_clk;
    initial begin
        #13;
        forever #40 link_clk = ~link_clk;
    end
    imu_out_words #(.SAMPLE_DIV(SDIV), .TIME_DIV(TDIV)) u_dut (
        .core_clk(core_clk), .rst(rst), .gyro_x(gyro_x), .gyro_y(gyro_y),
        .accel_z(accel_z), .temp_in(temp_in), .misc_control(misc_control),
        .decimation_setting(decimation_setting), .reset_cmd(reset_cmd),
        .sync_pin(sync_pin), .link_clk(link_clk), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data),
        .new_sample_flag_pin(new_sample_flag_pin));
    host_model u_host (.link_clk(link_clk), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data));
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Wait for an update pulse, then let the link copy settle
    task automatic wait_upd();
        int i;
        for (i = 0; i < 20000; i++) begin
            @(negedge core_clk);
            if (new_sample_flag_pin === 1'b1) break;
        end
        if (i == 20000) bad_count++;
        repeat (6) @(posedge link_clk);
    endtask
    task automatic t_words();
        logic [15:0] v;
        wait_upd();
        u_host.rd(ZACC_HI_ADDR, v);
        chk("accel_hi", 16'h8300, v);
        u_host.rd(ZACC_LO_ADDR, v);
        chk("accel_lo", 16'h1234, v);
        u_host.rd(TEMP_ADDR, v);
        chk("temp", 16'hfe70, v);
        u_host.rd(7'h40, v);
        chk("unmapped", UNMAPPED_READ, v);
        $display("test words done");
    endtask
    task automatic t_delta();
        logic [15:0] v;
        logic [31:0] ex, ey;
        for (int s = 0; s < 3; s++) begin
            @(negedge core_clk);
            decimation_setting = 11'(s);
            ex = 32'h00012345 * (s + 1);
            ey = 32'hfffffffd * (s + 1);
            wait_upd();
            wait_upd();
            u_host.rd(X_LO_ADDR, v);
            chk("x_lo", ex[15:0], v);
            u_host.rd(X_HI_ADDR, v);
            chk("x_hi", ex[31:16], v);
            wait_upd();
            u_host.rd(Y_LO_ADDR, v);
            chk("y_lo", ey[15:0], v);
            u_host.rd(Y_HI_ADDR, v);
            chk("y_hi", ey[31:16], v);
        end
        $display("test delta done");
    endtask
    task automatic t_count();
        logic [15:0] a, b;
        wait_upd();
        u_host.rd(CNT_ADDR, a);
        wait_upd();
        u_host.rd(CNT_ADDR, b);
        chk("count_step", a + 16'h0001, b);
        @(negedge core_clk);
        reset_cmd = 1'b1;
        @(negedge core_clk);
        reset_cmd = 1'b0;
        wait_upd();
        u_host.rd(CNT_ADDR, b);
        chk("count_clear", 16'h0001, b);
        $display("test count done");
    endtask
    task automatic t_time();
        logic [15:0] v;
        int n, e;
        wait_upd();
        u_host.rd(TIME_ADDR, v);
        chk("time_off", 16'h0000, v);
        @(negedge core_clk);
        misc_control = 16'h0008;
        wait_upd();
        @(negedge core_clk);
        sync_pin = 1'b1;
        for (n = 1; n < 20000; n++) begin
            @(negedge core_clk);
            if (new_sample_flag_pin === 1'b1) break;
        end
        sync_pin = 1'b0;
        repeat (6) @(posedge link_clk);
        u_host.rd(TIME_ADDR, v);
        e = (n - 4) / TDIV;
        chk("time_stamp", 16'(e), v);
        $display("test time done");
    endtask
    task automatic t_rate();
        int n;
        @(negedge core_clk);
        decimation_setting = 11'h000;
        wait_upd();
        for (n = 0; n < 1000; n++) begin
            @(negedge core_clk);
            if (new_sample_flag_pin === 1'b1) break;
        end
        for (n = 1; n < 1000; n++) begin
            @(negedge core_clk);
            if (new_sample_flag_pin === 1'b1) break;
        end
        chk("flag_period", 16'(SDIV), 16'(n));
        $display("test rate done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge link_clk);
        @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(posedge link_clk);
        t_words();
        t_delta();
        t_count();
        t_time();
        t_rate();
        results();
    end
    initial begin
        #300000;
        bad_count++;
        results();
    end
endmodule
